// ==== hdl/hvsp_port.sv ====
`timescale 1ns/100ps
module hvsp_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire hvsp_pkg::hvsp_bus_s bus,
  output logic [hvsp_pkg::DW-1:0] rdata,
  input wire hvsp_pkg::hvsp_mode_e mode,
  input wire logic key_scan,
  input wire logic [hvsp_pkg::SEG_W-1:0] seg_in,
  input wire logic [hvsp_pkg::DW-1:0] pin_four_in,
  input wire logic [hvsp_pkg::DW-1:0] pin_five_in,
  output hvsp_pkg::hvsp_pins_s pins_four,
  output hvsp_pkg::hvsp_pins_s pins_five,
  output logic supply_connect,
  output logic supply_gpio_en,
  output logic display_running
);
  localparam int DW = hvsp_pkg::DW;

  typedef struct packed {
    logic [DW-1:0] port_four_data;
    logic [DW-1:0] port_five_data;
    logic [DW-1:0] dir_four;
    logic [DW-1:0] dir_five;
    logic display_master_flag;
    logic [hvsp_pkg::RW-1:0] segment_range_field;
    logic display_enable_bit;
    logic supply_sel;
    logic [DW-1:0] rdata;
    hvsp_pkg::hvsp_pins_s p4;
    hvsp_pkg::hvsp_pins_s p5;
    logic supply_connect;
    logic supply_gpio_en;
  } hvsp_state_s;

  hvsp_state_s st;
  hvsp_state_s next_st;

  logic [DW-1:0] sel_four;
  logic [DW-1:0] sel_five;
  logic [DW-1:0] drive_four;
  logic [DW-1:0] drive_five;
  logic [DW-1:0] segv_four;
  logic [DW-1:0] segv_five;
  logic [DW-1:0] val_four;
  logic [DW-1:0] val_five;
  logic [DW-1:0] en_four;
  logic [DW-1:0] en_five;
  logic [DW-1:0] rd_four;
  logic [DW-1:0] rd_five;
  logic running;

  // Flag and enable both needed, so a flag clear stops driving at once
  assign running = st.display_master_flag && st.display_enable_bit;

  // Range field picks segments 0..range; map each pin to its segment number
  always_comb begin
    for (int i = 0; i < DW; i++) begin
      sel_four[i] = st.display_master_flag
        && ((hvsp_pkg::SEG_BASE_FOUR + i[hvsp_pkg::RW-1:0]) <= st.segment_range_field);
      sel_five[i] = st.display_master_flag
        && ((hvsp_pkg::SEG_BASE_FIVE - i[hvsp_pkg::RW-1:0]) <= st.segment_range_field);
      segv_four[i] = seg_in[hvsp_pkg::SEG_BASE_FOUR + i[hvsp_pkg::RW-1:0]];
      segv_five[i] = seg_in[hvsp_pkg::SEG_BASE_FIVE - i[hvsp_pkg::RW-1:0]];
    end
  end

  // Key scan stops segment drive; the pins fall back to their data and direction registers
  assign drive_four = (running && !key_scan) ? sel_four : '0;
  assign drive_five = (running && !key_scan) ? sel_five : '0;

  hvsp_pin_cell #(.W(DW)) u_cell_four (
    .data(st.port_four_data),
    .dir(st.dir_four),
    .seg_sel(sel_four),
    .seg_drive(drive_four),
    .seg_val(segv_four),
    .pin_in(pin_four_in),
    .drv_val(val_four),
    .drv_en(en_four),
    .rd_val(rd_four)
  );

  hvsp_pin_cell #(.W(DW)) u_cell_five (
    .data(st.port_five_data),
    .dir(st.dir_five),
    .seg_sel(sel_five),
    .seg_drive(drive_five),
    .seg_val(segv_five),
    .pin_in(pin_five_in),
    .drv_val(val_five),
    .drv_en(en_five),
    .rd_val(rd_five)
  );

  always_comb begin
    next_st = st;
    next_st.rdata = hvsp_pkg::DATA_RST;
    if (bus.wr) begin
      case (bus.addr)
        hvsp_pkg::ADDR_PORT_FOUR: next_st.port_four_data = bus.wdata;
        hvsp_pkg::ADDR_PORT_FIVE: next_st.port_five_data = bus.wdata;
        hvsp_pkg::ADDR_DIR_FOUR: next_st.dir_four = bus.wdata;
        hvsp_pkg::ADDR_DIR_FIVE: next_st.dir_five = bus.wdata;
        hvsp_pkg::ADDR_SEG_CTRL: begin
          next_st.display_master_flag = bus.wdata[hvsp_pkg::FLAG_BIT];
          next_st.segment_range_field =
            bus.wdata[hvsp_pkg::RANGE_LSB +: hvsp_pkg::RW];
        end
        hvsp_pkg::ADDR_DIGIT_BEGIN:
          next_st.display_enable_bit = bus.wdata[hvsp_pkg::ENABLE_BIT];
        hvsp_pkg::ADDR_SUPPLY: next_st.supply_sel = bus.wdata[hvsp_pkg::SUPPLY_BIT];
        default: next_st.rdata = hvsp_pkg::DATA_RST;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        hvsp_pkg::ADDR_PORT_FOUR: next_st.rdata = rd_four;
        hvsp_pkg::ADDR_PORT_FIVE: next_st.rdata = rd_five;
        hvsp_pkg::ADDR_DIR_FOUR: next_st.rdata = st.dir_four;
        hvsp_pkg::ADDR_DIR_FIVE: next_st.rdata = st.dir_five;
        hvsp_pkg::ADDR_SEG_CTRL: begin
          next_st.rdata[hvsp_pkg::FLAG_BIT] = st.display_master_flag;
          next_st.rdata[hvsp_pkg::RANGE_LSB +: hvsp_pkg::RW] = st.segment_range_field;
        end
        hvsp_pkg::ADDR_DIGIT_BEGIN:
          next_st.rdata[hvsp_pkg::ENABLE_BIT] = st.display_enable_bit;
        hvsp_pkg::ADDR_SUPPLY: next_st.rdata[hvsp_pkg::SUPPLY_BIT] = st.supply_sel;
        default: next_st.rdata = hvsp_pkg::DATA_RST;
      endcase
    end
    // Pin stage per operating mode; sleep keeps the registered drive
    case (mode)
      hvsp_pkg::HVSP_ACTIVE: begin
        next_st.p4.out = val_four;
        next_st.p4.oe = en_four;
        next_st.p4.pull_down = ~en_four;
        next_st.p5.out = val_five;
        next_st.p5.oe = en_five;
        next_st.p5.pull_down = ~en_five;
        next_st.supply_connect = st.supply_sel;
        next_st.supply_gpio_en = !st.supply_sel;
      end
      hvsp_pkg::HVSP_SLEEP: begin
        next_st.p4 = st.p4;
        next_st.p5 = st.p5;
        next_st.supply_gpio_en = 1'b0;
      end
      default: begin
        next_st.p4.oe = hvsp_pkg::DATA_RST;
        next_st.p4.pull_down = hvsp_pkg::ALL_ONES;
        next_st.p5.oe = hvsp_pkg::DATA_RST;
        next_st.p5.pull_down = hvsp_pkg::ALL_ONES;
        next_st.supply_gpio_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.port_four_data <= hvsp_pkg::DATA_RST;
      st.port_five_data <= hvsp_pkg::DATA_RST;
      st.segment_range_field <= hvsp_pkg::RANGE_RST;
      st.p4.pull_down <= hvsp_pkg::ALL_ONES;
      st.p5.pull_down <= hvsp_pkg::ALL_ONES;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign pins_four = st.p4;
  assign pins_five = st.p5;
  assign supply_connect = st.supply_connect;
  assign supply_gpio_en = st.supply_gpio_en;
  assign display_running = running;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_seg_ctrl_clear;
    bus.wr && bus.addr == hvsp_pkg::ADDR_SEG_CTRL && !bus.wdata[hvsp_pkg::FLAG_BIT];
  endsequence

  sequence s_read_four_all_seg;
    bus.rd && bus.addr == hvsp_pkg::ADDR_PORT_FOUR && (&sel_four);
  endsequence

  AST_P4_RESET: assert property (disable iff (1'b0) rst |=>
    st.port_four_data == hvsp_pkg::DATA_RST && pins_four.oe == hvsp_pkg::DATA_RST)
    else $error("port four not cleared by reset");

  AST_P5_RESET: assert property (disable iff (1'b0) rst |=>
    st.port_five_data == hvsp_pkg::DATA_RST && pins_five.oe == hvsp_pkg::DATA_RST)
    else $error("port five not cleared by reset");

  AST_DATA_WRITE: assert property (bus.wr && bus.addr == hvsp_pkg::ADDR_PORT_FIVE |=>
    st.port_five_data == $past(bus.wdata))
    else $error("port five write lost");

  AST_FLAG_LOW_GPIO: assert property (!st.display_master_flag |->
    sel_four == '0 && sel_five == '0)
    else $error("segment pin with master flag low");

  AST_SEG_DRIVE: assert property (mode == hvsp_pkg::HVSP_ACTIVE && drive_four[0] |=>
    pins_four.oe[0] && pins_four.out[0] == $past(seg_in[hvsp_pkg::SEG_BASE_FOUR]))
    else $error("segment not driven on port four");

  AST_SEG_READ: assert property (s_read_four_all_seg |=>
    rdata == $past(st.port_four_data))
    else $error("segment pin read did not return data register");

  AST_KEY_SCAN: assert property (key_scan |-> drive_four == '0 && drive_five == '0)
    else $error("segment driven during key scan");

  AST_ENABLE_GATE: assert property (!st.display_enable_bit |->
    drive_four == '0 && drive_five == '0)
    else $error("segment driven before enable");

  AST_FLAG_CLEAR: assert property (s_seg_ctrl_clear |=> drive_four == '0
    ##1 (mode != hvsp_pkg::HVSP_ACTIVE || pins_four.oe == $past(st.dir_four)))
    else $error("flag clear did not release segment pins");

  AST_LOW_POWER: assert property (mode == hvsp_pkg::HVSP_STANDBY
    || mode == hvsp_pkg::HVSP_SUBACTIVE |=> pins_five.oe == hvsp_pkg::DATA_RST
    && pins_five.pull_down == hvsp_pkg::ALL_ONES)
    else $error("port five driven in low-power mode");

  AST_SUPPLY_IDLE: assert property (mode != hvsp_pkg::HVSP_ACTIVE |=> !supply_gpio_en)
    else $error("supply pin used as port outside active mode");

  AST_GPIO_OUT: assert property (mode == hvsp_pkg::HVSP_ACTIVE && !drive_five[3]
    && st.dir_five[3] |=> pins_five.oe[3] && pins_five.out[3] == $past(st.port_five_data[3]))
    else $error("output pin does not follow data register");

  sequence s_enable_write;
    bus.wr && bus.addr == hvsp_pkg::ADDR_DIGIT_BEGIN && bus.wdata[hvsp_pkg::ENABLE_BIT];
  endsequence

  sequence s_read_five_input;
    bus.rd && bus.addr == hvsp_pkg::ADDR_PORT_FIVE && !sel_five[0] && !st.dir_five[0];
  endsequence

  AST_START_AFTER_ENABLE: assert property (s_enable_write
    ##1 st.display_master_flag |-> display_running)
    else $error("display not running after enable");

  AST_SEG_DRIVE_FIVE: assert property (mode == hvsp_pkg::HVSP_ACTIVE
    && drive_five[7] |=> pins_five.oe[7]
    && pins_five.out[7] == $past(seg_in[hvsp_pkg::SEG_BASE_FIVE - 5'h07]))
    else $error("segment not driven on port five");

  AST_READ_INPUT: assert property (s_read_five_input |=>
    rdata[0] == $past(pin_five_in[0]))
    else $error("input pin read did not return pin level");

  AST_KEY_SCAN_PIN: assert property (mode == hvsp_pkg::HVSP_ACTIVE && key_scan
    && !st.dir_four[0] |=> !pins_four.oe[0])
    else $error("segment pin not released during key scan");

  // Sleep freezes the pin stage of both ports, out, enable and pull alike
  AST_SLEEP_HOLD: assert property (mode == hvsp_pkg::HVSP_SLEEP |=>
    pins_four == $past(pins_four) && pins_five == $past(pins_five))
    else $error("pin state not retained in sleep");

  AST_P4_LOW_POWER: assert property (mode == hvsp_pkg::HVSP_STANDBY
    || mode == hvsp_pkg::HVSP_WATCH || mode == hvsp_pkg::HVSP_SUBACTIVE
    |=> pins_four.oe == hvsp_pkg::DATA_RST && pins_four.pull_down == hvsp_pkg::ALL_ONES)
    else $error("port four driven in low-power mode");

  AST_SUPPLY_ACTIVE: assert property (mode == hvsp_pkg::HVSP_ACTIVE |=>
    supply_connect == $past(st.supply_sel) && supply_gpio_en == !$past(st.supply_sel))
    else $error("supply pin does not follow its select in active mode");

  AST_SUPPLY_HOLD: assert property (mode != hvsp_pkg::HVSP_ACTIVE |=>
    supply_connect == $past(supply_connect))
    else $error("supply connection changed outside active mode");

  AST_RDATA_IDLE: assert property (!bus.rd |=> rdata == hvsp_pkg::DATA_RST)
    else $error("read data present without a read");
endmodule // hvsp_port

// ==== hdl/hvsp_pkg.sv ====
package hvsp_pkg;
  localparam int DW = 8;
  localparam int AW = 16;
  localparam int RW = 5;
  localparam logic [AW-1:0] ADDR_PORT_FOUR = 16'hFFD4;
  localparam logic [AW-1:0] ADDR_PORT_FIVE = 16'hFFD5;
  localparam logic [AW-1:0] ADDR_SEG_CTRL = 16'hFFD8;
  localparam logic [AW-1:0] ADDR_DIGIT_BEGIN = 16'hFFD9;
  localparam logic [AW-1:0] ADDR_DIR_FOUR = 16'hFFDA;
  localparam logic [AW-1:0] ADDR_DIR_FIVE = 16'hFFDB;
  localparam logic [AW-1:0] ADDR_SUPPLY = 16'hFFDC;
  localparam int FLAG_BIT = 7;
  localparam int RANGE_LSB = 0;
  localparam int ENABLE_BIT = 7;
  localparam int SUPPLY_BIT = 0;
  localparam logic [DW-1:0] DATA_RST = 8'h00;
  localparam logic [DW-1:0] ALL_ONES = 8'hFF;
  localparam logic [RW-1:0] RANGE_RST = 5'h00;
  // Segment number of bit 0; port four counts up, port five counts down
  localparam logic [RW-1:0] SEG_BASE_FOUR = 5'h10;
  localparam logic [RW-1:0] SEG_BASE_FIVE = 5'h0F;
  localparam int SEG_W = 24;

  typedef enum logic [4:0] {
    HVSP_ACTIVE = 5'h01,
    HVSP_SLEEP = 5'h02,
    HVSP_STANDBY = 5'h04,
    HVSP_WATCH = 5'h08,
    HVSP_SUBACTIVE = 5'h10
  } hvsp_mode_e;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } hvsp_bus_s;

  typedef struct packed {
    logic [DW-1:0] out;
    logic [DW-1:0] oe;
    logic [DW-1:0] pull_down;
  } hvsp_pins_s;
endpackage

// ==== hdl/hvsp_pin_cell.sv ====
`timescale 1ns/100ps
module hvsp_pin_cell #(
  parameter int W = 8
) (
  input wire logic [W-1:0] data,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] seg_sel,
  input wire logic [W-1:0] seg_drive,
  input wire logic [W-1:0] seg_val,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] drv_val,
  output logic [W-1:0] drv_en,
  output logic [W-1:0] rd_val
);
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (seg_drive[i]) begin
        drv_val[i] = seg_val[i];
        drv_en[i] = 1'b1;
      end else begin
        drv_val[i] = data[i];
        drv_en[i] = dir[i];
      end
      if (seg_sel[i] || dir[i]) begin
        rd_val[i] = data[i];
      end else begin
        rd_val[i] = pin_in[i];
      end
    end
  end
endmodule // hvsp_pin_cell

// ==== bench/hvsp_pin_model.sv ====
`timescale 1ns/100ps
// External lines: a driven pin shows its own level; a released one follows the
// far-side source, which overrides the weak pull-down
module hvsp_pin_model (
  input wire hvsp_pkg::hvsp_pins_s pins_four,
  input wire hvsp_pkg::hvsp_pins_s pins_five,
  input wire logic [15:0] ext_level,
  output logic [7:0] pin_four_in,
  output logic [7:0] pin_five_in
);
  function automatic logic [7:0] level(input hvsp_pkg::hvsp_pins_s p, input logic [7:0] e);
    return (p.oe & p.out) | (~p.oe & e);
  endfunction
  assign pin_four_in = level(pins_four, ext_level[15:8]);
  assign pin_five_in = level(pins_five, ext_level[7:0]);
endmodule // hvsp_pin_model

// ==== bench/hvsp_port_tb.sv ====
`timescale 1ns/100ps
module hvsp_port_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  hvsp_pkg::hvsp_bus_s bus = '0;
  hvsp_pkg::hvsp_mode_e mode = hvsp_pkg::HVSP_ACTIVE;
  logic key_scan = 1'b0;
  logic [23:0] seg_in = 24'hA5C100;
  logic [15:0] ext_level = 16'h003C;
  logic [7:0] rdata, p4_in, p5_in, rd_val;
  hvsp_pkg::hvsp_pins_s p4, p5;
  logic sup_con, sup_gpio, running;
  int err_count = 0;
  int checks_done = 0;

  always #5 ref_clk = ~ref_clk;

  hvsp_port u_hvsp_port (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata),
    .mode(mode), .key_scan(key_scan), .seg_in(seg_in), .pin_four_in(p4_in),
    .pin_five_in(p5_in), .pins_four(p4), .pins_five(p5), .supply_connect(sup_con),
    .supply_gpio_en(sup_gpio), .display_running(running));
  hvsp_pin_model u_hvsp_pin_model (.pins_four(p4), .pins_five(p5),
    .ext_level(ext_level), .pin_four_in(p4_in), .pin_five_in(p5_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk) bus <= '0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk) bus <= '0;
    #1 rd_val = rdata;
  endtask

  // Pins follow one edge after a mode change and two edges after a register write
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // Outputs first, so reads return the data registers and not pin levels
  task automatic t_reset();
    #1;
    check({p4.oe, p4.pull_down, 7'h00, sup_con}, 24'h00FF00);
    wr(16'hFFDA, 8'hFF);
    wr(16'hFFDB, 8'hFF);
    rd(16'hFFD4);
    check(rd_val, 8'h00);
    rd(16'hFFD5);
    check(rd_val, 8'h00);
  endtask

  task automatic t_regs();
    wr(16'hFFD4, 8'hA5);
    wr(16'hFFD5, 8'h5A);
    rd(16'hFFD4);
    check(rd_val, 8'hA5);
    rd(16'hFFD5);
    check(rd_val, 8'h5A);
    rd(16'hFFD7);
    check(rd_val, 8'h00);
  endtask

  task automatic t_gpio();
    wr(16'hFFDA, 8'hFF);
    wr(16'hFFDB, 8'h00);
    settle();
    check({p4.out, p4.oe}, 16'hA5FF);
    rd(16'hFFD5);
    check(rd_val, 8'h3C);
  endtask

  task automatic t_seg();
    wr(16'hFFDA, 8'h00);
    wr(16'hFFD8, 8'h1F);
    wr(16'hFFD9, 8'h80);
    settle();
    check({running, p4.oe, p5.oe}, 17'h00000);
    wr(16'hFFD9, 8'h00);
    wr(16'hFFD8, 8'h91);
    settle();
    check({running, p5.oe}, 9'h000);
    wr(16'hFFD9, 8'h80);
    settle();
    check(running, 1'b1);
    check({p4.oe, p4.out & 8'h03, p5.oe, p5.out}, 32'h0301FF83);
    rd(16'hFFD5);
    check(rd_val, 8'h5A);
    wr(16'hFFD8, 8'h97);
    rd(16'hFFD4);
    check(rd_val, 8'hA5);
    @(posedge ref_clk) key_scan <= 1'b1;
    settle();
    check({p4.oe, p5.oe}, 16'h0000);
    @(posedge ref_clk) key_scan <= 1'b0;
    wr(16'hFFD8, 8'h11);
    settle();
    check({running, p4.oe, p5.oe}, 17'h00000);
  endtask

  task automatic t_mode();
    hvsp_pkg::hvsp_mode_e ms[3];
    ms = '{hvsp_pkg::HVSP_STANDBY, hvsp_pkg::HVSP_WATCH, hvsp_pkg::HVSP_SUBACTIVE};
    wr(16'hFFDA, 8'hFF);
    foreach (ms[i]) begin
      @(posedge ref_clk) mode <= ms[i];
      settle();
      check({p4.oe, p4.pull_down}, 16'h00FF);
    end
    @(posedge ref_clk) mode <= hvsp_pkg::HVSP_ACTIVE;
    settle();
    check({p4.oe, p4.pull_down, p4.out}, 24'hFF00A5);
    @(posedge ref_clk) mode <= hvsp_pkg::HVSP_SLEEP;
    wr(16'hFFDA, 8'h00);
    settle();
    check({p4.oe, p4.out}, 16'hFFA5);
    @(posedge ref_clk) mode <= hvsp_pkg::HVSP_ACTIVE;
    settle();
    check(p4.oe, 8'h00);
  endtask

  task automatic t_supply();
    wr(16'hFFDC, 8'h01);
    settle();
    check({sup_con, sup_gpio}, 2'b10);
    wr(16'hFFDC, 8'h00);
    settle();
    check({sup_con, sup_gpio}, 2'b01);
    @(posedge ref_clk) mode <= hvsp_pkg::HVSP_STANDBY;
    settle();
    check(sup_gpio, 1'b0);
    @(posedge ref_clk) mode <= hvsp_pkg::HVSP_ACTIVE;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_gpio();
    t_seg();
    t_mode();
    t_supply();
    wrap_up();
  end

  // Whole sequence is under 150 cycles
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
endmodule // hvsp_port_tb
